//--- core/spi_pkg.sv
// Constants and types for the receive payload pointer interpreter
package spi_pkg;
  // Register byte offsets
  localparam logic [7:0] SPI_OFF_CTRL   = 8'h00;
  localparam logic [7:0] SPI_OFF_STATUS = 8'h04;
  localparam logic [7:0] SPI_OFF_PEND   = 8'h08;
  localparam logic [7:0] SPI_OFF_MASKA  = 8'h0c;
  localparam logic [7:0] SPI_OFF_MASKB  = 8'h10;
  localparam logic [7:0] SPI_OFF_PTR    = 8'h14;
  // Field positions
  localparam int SPI_BIT_SDH   = 0;
  localparam int SPI_BIT_ALARM = 0;
  localparam int SPI_BIT_LOSS  = 1;
  localparam int SPI_BIT_POINTER_NORMAL_STATE  = 2;
  // Reset values
  localparam logic [1:0] SPI_RST_LATCH = 2'h2;
  localparam logic [1:0] SPI_RST_MASK  = 2'h0;
  // Pointer word layout and codes
  localparam int          SPI_FLAG_HI   = 15;
  localparam int          SPI_FLAG_LO   = 12;
  localparam int          SPI_SS_HI     = 11;
  localparam int          SPI_SS_LO     = 10;
  localparam logic [3:0]  SPI_FLAG_POINTER_NORMAL_STATE = 4'h6;
  localparam logic [3:0]  SPI_FLAG_NDF  = 4'h9;
  localparam logic [1:0]  SPI_SS_SDH    = 2'h2;
  localparam logic [15:0] SPI_AIS_WORD  = 16'hffff;
  localparam logic [9:0]  SPI_CI_VALUE  = 10'h3ff;
  localparam logic [9:0]  SPI_PTR_MAX   = 10'h30e;
  localparam logic [9:0]  SPI_I_MASK    = 10'h2aa;
  localparam logic [9:0]  SPI_D_MASK    = 10'h155;
  // Secondary positions checked in SDH mode
  localparam logic [7:0]  SPI_SDH_LAST  = 8'h40;
  // Persistence counts in frames, then the bit majority thresholds for adjustments
  localparam logic [1:0]  SPI_N_POINTER_NORMAL_STATE    = 2'h3;
  localparam logic [1:0]  SPI_N_AIS     = 2'h3;
  localparam logic [3:0]  SPI_N_INV     = 4'h8;
  localparam logic [1:0]  SPI_N_HOLD    = 2'h3;
  localparam logic [3:0]  SPI_SONET_MAJ = 4'h8;
  localparam logic [2:0]  SPI_SDH_MAJ   = 3'h3;

  typedef enum logic [1:0] {
    SPI_ST_POINTER_NORMAL_STATE = 2'b00,
    SPI_ST_LOP  = 2'b01,
    SPI_ST_AIS  = 2'b10
  } spi_state_e;

  typedef enum logic [2:0] {
    SPI_C_INVALID = 3'b000,
    SPI_C_SAME    = 3'b001,
    SPI_C_NEWVAL  = 3'b010,
    SPI_C_NDF     = 3'b011,
    SPI_C_AIS     = 3'b100,
    SPI_C_INC     = 3'b101,
    SPI_C_DEC     = 3'b110
  } spi_class_e;
endpackage

//--- core/spi_pointer_interp.sv
// Receive payload pointer interpreter with APB register access
`timescale 1ns/1ps
module spi_pointer_interp
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Received pointer octet pairs
  input  wire logic        ptr_valid,
  input  wire logic [7:0]  ptr_pos,
  input  wire logic [15:0] ptr_word,
  input  wire logic        frame_done,
  input  wire logic        frame_lof,
  // Status and interrupts
  output logic             pointer_normal_state,
  output logic             interrupt_out_a,
  output logic             interrupt_out_b
);
  import spi_pkg::*;

  typedef struct packed {
    spi_state_e  st;
    logic [9:0]  acc;
    logic [9:0]  cand;
    logic [1:0]  ncnt;
    logic [1:0]  acnt;
    logic [3:0]  icnt;
    logic [1:0]  hold;
    logic [15:0] prim;
    logic        conc_bad;
    logic        sdh;
    logic [1:0]  maska;
    logic [1:0]  maskb;
    logic [1:0]  pend;
    logic [1:0]  latch;
    logic [31:0] rdata;
    logic        err;
  } spi_regs_s;

  spi_regs_s  r_reg;
  spi_regs_s  r_next;
  spi_class_e cls;
  logic [9:0] val;
  logic [3:0] inv_i;
  logic [3:0] inv_d;
  logic [1:0] cond;
  logic [1:0] evt;
  logic       apb_rd;
  logic       apb_wr;
  logic       sec_ok;

  // Count of ones in a ten-bit vector
  function automatic logic [3:0] ones10(input logic [9:0] v);
    logic [3:0] n;
    n = 4'h0;
    for (int k = 0; k < 10; k++)
    begin
      n = n + {3'h0, v[k]};
    end
    return n;
  endfunction

  // Three of four flag bits match a code
  function automatic logic flag_ok(input logic [3:0] f, input logic [3:0] code);
    logic [3:0] x;
    x = f ^ code;
    return (x == 4'h0) || (x == 4'h1) || (x == 4'h2) || (x == 4'h4) || (x == 4'h8);
  endfunction

  // Size bits match, or are ignored in SONET mode
  function automatic logic ss_ok(input logic [15:0] w, input logic sdh);
    return !sdh || (w[SPI_SS_HI:SPI_SS_LO] == SPI_SS_SDH);
  endfunction

  // Fields of the stored primary pointer
  assign val   = r_reg.prim[9:0];
  assign inv_i = ones10((val ^ r_reg.acc) & SPI_I_MASK);
  assign inv_d = ones10((val ^ r_reg.acc) & SPI_D_MASK);

  // Checks a secondary position for a concatenation indicator
  always_comb
  begin
    sec_ok = (ptr_word == SPI_AIS_WORD) ||
             (flag_ok(ptr_word[SPI_FLAG_HI:SPI_FLAG_LO], SPI_FLAG_POINTER_NORMAL_STATE) &&
              (ptr_word[9:0] == SPI_CI_VALUE) && ss_ok(ptr_word, r_reg.sdh));
  end

  // Classification of the frame's primary pointer
  always_comb
  begin
    logic fn;
    logic inc;
    logic dec;
    fn  = flag_ok(r_reg.prim[SPI_FLAG_HI:SPI_FLAG_LO], SPI_FLAG_POINTER_NORMAL_STATE);
    inc = 1'b0;
    dec = 1'b0;
    if (r_reg.sdh)
    begin
      inc = (inv_i >= {1'b0, SPI_SDH_MAJ}) && (inv_d < {1'b0, SPI_SDH_MAJ});
      dec = (inv_d >= {1'b0, SPI_SDH_MAJ}) && (inv_i < {1'b0, SPI_SDH_MAJ});
    end
    else
    begin
      inc = ones10(~(val ^ r_reg.acc ^ SPI_I_MASK)) >= SPI_SONET_MAJ;
      dec = ones10(~(val ^ r_reg.acc ^ SPI_D_MASK)) >= SPI_SONET_MAJ;
    end
    cls = SPI_C_INVALID;
    if (r_reg.conc_bad)
      cls = SPI_C_INVALID;
    else if (r_reg.prim == SPI_AIS_WORD)
      cls = SPI_C_AIS;
    else if (!ss_ok(r_reg.prim, r_reg.sdh))
      cls = SPI_C_INVALID;
    else if (flag_ok(r_reg.prim[SPI_FLAG_HI:SPI_FLAG_LO], SPI_FLAG_NDF) &&
             val <= SPI_PTR_MAX)
      cls = SPI_C_NDF;
    else if (fn && val == r_reg.acc)
      cls = SPI_C_SAME;
    else if (fn && inc)
      cls = SPI_C_INC;
    else if (fn && dec)
      cls = SPI_C_DEC;
    else if (fn && val <= SPI_PTR_MAX)
      cls = SPI_C_NEWVAL;
  end

  // APB strobes and present conditions
  assign apb_rd = psel && penable && !pwrite;
  assign apb_wr = psel && penable && pwrite;
  assign cond   = {r_next.st == SPI_ST_LOP, r_next.st == SPI_ST_AIS};
  assign evt    = {(r_reg.st == SPI_ST_LOP) != (r_next.st == SPI_ST_LOP),
                   (r_reg.st == SPI_ST_AIS) != (r_next.st == SPI_ST_AIS)};

  // Next state of the whole block
  always_comb
  begin
    logic valid;
    r_next = r_reg;
    valid  = 1'b0;
    // Capture pointers of the frame in progress
    if (ptr_valid)
    begin
      if (ptr_pos == 8'h00)
        r_next.prim = ptr_word;
      else if ((!r_reg.sdh || ptr_pos < SPI_SDH_LAST) && !sec_ok)
        r_next.conc_bad = 1'b1;
    end
    // Evaluate the frame once all its pointers are in
    if (frame_done)
    begin
      r_next.conc_bad = 1'b0;
      if (r_reg.hold != 2'h0)
        r_next.hold = r_reg.hold - 2'h1;
      // Persistence of a new normal value; an increment or decrement
      // look-alike still carries a normal flag and counts here too
      if ((cls == SPI_C_SAME || cls == SPI_C_NEWVAL || cls == SPI_C_INC ||
           cls == SPI_C_DEC) && val <= SPI_PTR_MAX)
      begin
        if (r_reg.ncnt != 2'h0 && val == r_reg.cand)
          r_next.ncnt = (r_reg.ncnt == SPI_N_POINTER_NORMAL_STATE) ? SPI_N_POINTER_NORMAL_STATE : r_reg.ncnt + 2'h1;
        else
          r_next.ncnt = 2'h1;
        r_next.cand = val;
      end
      else
        r_next.ncnt = 2'h0;
      r_next.acnt = (cls == SPI_C_AIS) ?
                    ((r_reg.acnt == SPI_N_AIS) ? SPI_N_AIS : r_reg.acnt + 2'h1) : 2'h0;
      case (r_reg.st)
        SPI_ST_POINTER_NORMAL_STATE:
        begin
          if (cls == SPI_C_NDF)
          begin
            r_next.acc  = val;
            r_next.hold = SPI_N_HOLD;
            valid       = 1'b1;
          end
          else if ((cls == SPI_C_INC || cls == SPI_C_DEC) && r_reg.hold == 2'h0)
          begin
            if (cls == SPI_C_INC)
              r_next.acc = (r_reg.acc == SPI_PTR_MAX) ? 10'h000 : r_reg.acc + 10'h001;
            else
              r_next.acc = (r_reg.acc == 10'h000) ? SPI_PTR_MAX : r_reg.acc - 10'h001;
            r_next.hold = SPI_N_HOLD;
            valid       = 1'b1;
          end
          else
            valid = (cls == SPI_C_SAME);
        end
        SPI_ST_AIS:
          valid = (cls == SPI_C_AIS);
        default:
          valid = 1'b1;
      endcase
      r_next.icnt = valid ? 4'h0 :
                    ((r_reg.icnt == SPI_N_INV) ? SPI_N_INV : r_reg.icnt + 4'h1);
      // State moves, three states only; the invalid count restarts on entry
      // to normal or alarm state, whose entry frames are valid there
      if (r_next.ncnt == SPI_N_POINTER_NORMAL_STATE)
      begin
        r_next.st   = SPI_ST_POINTER_NORMAL_STATE;
        r_next.acc  = val;
        r_next.icnt = 4'h0;
      end
      else if (r_next.acnt == SPI_N_AIS && r_reg.st != SPI_ST_AIS)
      begin
        r_next.st   = SPI_ST_AIS;
        r_next.icnt = 4'h0;
      end
      else if (r_next.icnt == SPI_N_INV && r_reg.st != SPI_ST_LOP)
        r_next.st = SPI_ST_LOP;
    end
    // Loss of frame alignment restarts interpretation
    if (frame_lof)
    begin
      r_next.st       = SPI_ST_LOP;
      r_next.ncnt     = 2'h0;
      r_next.acnt     = 2'h0;
      r_next.icnt     = 4'h0;
      r_next.hold     = 2'h0;
      r_next.conc_bad = 1'b0;
    end
    // Register reads and writes
    r_next.err   = 1'b0;
    r_next.rdata = 32'h0000_0000;
    if (psel && !penable)
    begin
      if (paddr == SPI_OFF_CTRL)
        r_next.rdata = {31'h0, r_reg.sdh};
      else if (paddr == SPI_OFF_STATUS)
        r_next.rdata = {29'h0, r_reg.st == SPI_ST_POINTER_NORMAL_STATE, r_reg.latch};
      else if (paddr == SPI_OFF_PEND)
        r_next.rdata = {30'h0, r_reg.pend};
      else if (paddr == SPI_OFF_MASKA)
        r_next.rdata = {30'h0, r_reg.maska};
      else if (paddr == SPI_OFF_MASKB)
        r_next.rdata = {30'h0, r_reg.maskb};
      else if (paddr == SPI_OFF_PTR)
        r_next.rdata = {22'h0, r_reg.acc};
      else
        r_next.err = 1'b1;
    end
    if (apb_wr)
    begin
      if (paddr == SPI_OFF_CTRL)
        r_next.sdh = pwdata[SPI_BIT_SDH];
      else if (paddr == SPI_OFF_MASKA)
        r_next.maska = pwdata[1:0];
      else if (paddr == SPI_OFF_MASKB)
        r_next.maskb = pwdata[1:0];
    end
    // Latched status: a read reloads the present condition, events win
    if (apb_rd && paddr == SPI_OFF_STATUS)
      r_next.latch = cond | evt;
    else
      r_next.latch = r_reg.latch | evt;
    // Pending bits clear on read, events win
    if (apb_rd && paddr == SPI_OFF_PEND)
      r_next.pend = evt;
    else
      r_next.pend = r_reg.pend | evt;
  end

  // State register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      r_reg       <= '0;
      r_reg.st    <= SPI_ST_LOP;
      r_reg.latch <= SPI_RST_LATCH;
      r_reg.maska <= SPI_RST_MASK;
      r_reg.maskb <= SPI_RST_MASK;
    end
    else
      r_reg <= r_next;
  end

  // Outputs
  assign prdata               = r_reg.rdata;
  assign pslverr              = r_reg.err && psel && penable;
  assign pready               = 1'b1;
  assign pointer_normal_state = (r_reg.st == SPI_ST_POINTER_NORMAL_STATE);
  assign interrupt_out_a      = |(r_reg.pend & r_reg.maska);
  assign interrupt_out_b      = |(r_reg.pend & r_reg.maskb);

  // Checks
  sequence s_pointer_normal_state_frame;
    frame_done && !frame_lof && r_reg.st == SPI_ST_POINTER_NORMAL_STATE;
  endsequence

  AST_LOF_RESTART: assert property (@(posedge pclk) disable iff (!presetn)
    frame_lof |=> r_reg.st == SPI_ST_LOP && r_reg.icnt == 4'h0 && r_reg.ncnt == 2'h0)
    else $error("frame loss did not restart in loss state");
  AST_AIS_ENTRY: assert property (@(posedge pclk) disable iff (!presetn)
    r_reg.st == SPI_ST_AIS && $past(r_reg.st) != SPI_ST_AIS |->
    $past(r_reg.acnt) == 2'h2 && $past(frame_done))
    else $error("alarm state entered without three alarm frames");
  AST_LOP_ENTRY: assert property (@(posedge pclk) disable iff (!presetn)
    r_reg.st == SPI_ST_LOP && $past(r_reg.st) != SPI_ST_LOP && !$past(frame_lof) |->
    $past(r_reg.icnt) == 4'h7)
    else $error("loss state entered without eight invalid frames");
  AST_NDF_LOAD: assert property (@(posedge pclk) disable iff (!presetn)
    s_pointer_normal_state_frame ##0 cls == SPI_C_NDF |=>
    r_reg.st == SPI_ST_POINTER_NORMAL_STATE && r_reg.acc == $past(val) && r_reg.hold == SPI_N_HOLD)
    else $error("new data pointer not accepted");
  AST_INC_STEP: assert property (@(posedge pclk) disable iff (!presetn)
    s_pointer_normal_state_frame ##0 cls == SPI_C_INC && r_reg.hold == 2'h0 && r_reg.acc < SPI_PTR_MAX
    && r_next.ncnt != SPI_N_POINTER_NORMAL_STATE |=> r_reg.acc == $past(r_reg.acc) + 10'h001)
    else $error("increment did not step pointer");
  AST_HOLDOFF: assert property (@(posedge pclk) disable iff (!presetn)
    s_pointer_normal_state_frame ##0 (cls == SPI_C_INC || cls == SPI_C_DEC) && r_reg.hold != 2'h0
    && r_next.ncnt != SPI_N_POINTER_NORMAL_STATE |=> $stable(r_reg.acc))
    else $error("adjustment taken during hold-off");
  AST_SDH_BOTH: assert property (@(posedge pclk) disable iff (!presetn)
    r_reg.sdh && inv_i >= 4'h3 && inv_d >= 4'h3 |-> cls != SPI_C_INC && cls != SPI_C_DEC)
    else $error("adjustment with both bit groups inverted");
  AST_ALARM_PEND: assert property (@(posedge pclk) disable iff (!presetn)
    evt[0] |=> r_reg.pend[0] && r_reg.latch[0] ##1 r_reg.pend[0] || $past(apb_rd))
    else $error("alarm change not recorded");
  AST_IRQ_A: assert property (@(posedge pclk) disable iff (!presetn)
    evt[1] && r_reg.maska[1] && !(apb_wr && paddr == SPI_OFF_MASKA) |=> interrupt_out_a)
    else $error("masked-in loss event gave no interrupt");
  AST_APB_ERR: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && paddr > SPI_OFF_PTR ##1 psel && penable |-> pslverr)
    else $error("unmapped address not refused");
  AST_POINTER_NORMAL_STATE_ENTRY: assert property (@(posedge pclk) disable iff (!presetn)
    r_reg.st == SPI_ST_POINTER_NORMAL_STATE && $past(r_reg.st) != SPI_ST_POINTER_NORMAL_STATE |->
    $past(r_reg.ncnt) == 2'h2 && $past(frame_done))
    else $error("normal state entered without three equal pointers");
  AST_DEC_STEP: assert property (@(posedge pclk) disable iff (!presetn)
    s_pointer_normal_state_frame ##0 cls == SPI_C_DEC && r_reg.hold == 2'h0 && r_reg.acc > 10'h000
    && r_next.ncnt != SPI_N_POINTER_NORMAL_STATE |=> r_reg.acc == $past(r_reg.acc) - 10'h001)
    else $error("decrement did not step pointer");
  AST_IRQ_B: assert property (@(posedge pclk) disable iff (!presetn)
    evt[0] && r_reg.maskb[0] && !(apb_wr && paddr == SPI_OFF_MASKB) |=> interrupt_out_b)
    else $error("masked-in alarm event gave no interrupt");
  AST_PEND_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    r_reg.pend[1] && !(apb_rd && paddr == SPI_OFF_PEND) |=> r_reg.pend[1])
    else $error("loss pending bit cleared without a read");
endmodule // spi_pointer_interp

//--- sim/spi_line_tx.sv
// Line transmitter model that feeds received pointer pairs frame by frame
`timescale 1ns/1ps
module spi_line_tx
(
  // Clock
  input  wire logic        pclk,
  // Pointer pairs toward the interpreter
  output logic             ptr_valid,
  output logic [7:0]       ptr_pos,
  output logic [15:0]      ptr_word,
  output logic             frame_done
);
  // Idle line at time zero
  initial
  begin
    ptr_valid  = 1'b0;
    ptr_pos    = 8'h00;
    ptr_word   = 16'h0000;
    frame_done = 1'b0;
  end

  // Primary pair, then n secondary pairs, then the frame mark one cycle later
  task automatic send(input logic [15:0] prim, input logic [15:0] sec, input int n);
    for (int p = 0; p <= n; p++)
    begin
      @(posedge pclk);
      ptr_valid <= 1'b1;
      ptr_pos   <= 8'(p);
      ptr_word  <= (p == 0) ? prim : sec;
    end
    @(posedge pclk);
    ptr_valid  <= 1'b0;
    ptr_word   <= ~ptr_word; // Released line never shows the stale word
    frame_done <= 1'b1;
    @(posedge pclk);
    frame_done <= 1'b0;
  endtask
endmodule // spi_line_tx

//--- sim/spi_pointer_interp_tb.sv
// Self-checking bench for the receive pointer interpreter
`timescale 1ns/1ps
module spi_pointer_interp_tb;
  import spi_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, frame_lof, pready, pslverr, err;
  logic        ptr_valid, frame_done, pns, irq_a, irq_b;
  logic [7:0]  paddr, ptr_pos;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] ptr_word;
  logic [9:0]  v;
  int          fails = 0;
  int          samples_checked = 0;

  spi_pointer_interp u_spi_pointer_interp (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ptr_valid(ptr_valid), .ptr_pos(ptr_pos),
    .ptr_word(ptr_word), .frame_done(frame_done), .frame_lof(frame_lof),
    .pointer_normal_state(pns), .interrupt_out_a(irq_a), .interrupt_out_b(irq_b));

  spi_line_tx u_spi_line_tx (.pclk(pclk), .ptr_valid(ptr_valid), .ptr_pos(ptr_pos),
    .ptr_word(ptr_word), .frame_done(frame_done));

  // Clock at 20 MHz
  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; read data and error taken at the completing edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50)
      fails++;
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Register read against expectation
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask

  // Flag code with at most one bit wrong
  function automatic logic [3:0] fn(input logic [3:0] base);
    int r;
    r = $urandom % 5;
    return (r == 4) ? base : base ^ (4'h1 << r);
  endfunction

  function automatic logic [15:0] nw(input logic [9:0] x);
    return {fn(SPI_FLAG_POINTER_NORMAL_STATE), SPI_SS_SDH, x};
  endfunction

  function automatic logic [9:0] inc(input logic [9:0] x);
    return (x == 10'h30e) ? 10'h000 : x + 10'h001;
  endfunction

  // k frames of one primary word with matching secondaries
  task automatic frm(input logic [15:0] w, input int k);
    repeat (k)
      u_spi_line_tx.send(w, (w == SPI_AIS_WORD) ? SPI_AIS_WORD : nw(SPI_CI_VALUE), 3);
    @(negedge pclk);
  endtask

  task automatic finish_test();
    $display("fails=%0d samples_checked=%0d", fails, samples_checked);
    if (fails == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Watchdog
  initial
  begin
    #2000000;
    fails++;
    finish_test();
  end

  // Main sequence
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    frame_lof = 1'b0;
    void'($urandom(32'h5a3f917c));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rchk(SPI_OFF_STATUS, 32'h2);
    rchk(SPI_OFF_PEND, 32'h0);
    apb(1'b0, 8'h18, 32'h0);
    check(err, 1'b1);
    apb(1'b1, SPI_OFF_MASKA, 32'h2);
    apb(1'b1, SPI_OFF_MASKB, 32'h1);
    rchk(SPI_OFF_MASKA, 32'h2);
    // Three equal normal pointers enter normal state
    v = 10'($urandom % 783);
    frm(nw(v), 2);
    check(pns, 1'b0);
    frm(nw(v), 1);
    check({irq_b, irq_a, pns}, 3'b011);
    rchk(SPI_OFF_STATUS, 32'h6);
    rchk(SPI_OFF_STATUS, 32'h4);
    rchk(SPI_OFF_PEND, 32'h2);
    rchk(SPI_OFF_PEND, 32'h0);
    check(irq_a, 1'b0);
    rchk(SPI_OFF_PTR, {22'h0, v});
    // New data flag at the top value, then an increment in hold-off
    frm({fn(SPI_FLAG_NDF), SPI_SS_SDH, 10'h30e}, 1);
    check(pns, 1'b1);
    rchk(SPI_OFF_PTR, 32'h30e);
    frm(nw(10'h30e ^ SPI_I_MASK), 1);
    rchk(SPI_OFF_PTR, 32'h30e);
    frm(nw(10'h30e), 3);
    // Nine of ten bits match, size bits ignored: wraps to zero
    frm({fn(SPI_FLAG_POINTER_NORMAL_STATE), 2'b00, 10'h30e ^ SPI_I_MASK ^ 10'h001}, 1);
    rchk(SPI_OFF_PTR, 32'h0);
    frm(nw(SPI_D_MASK), 1);
    rchk(SPI_OFF_PTR, 32'h0);
    frm(nw(10'h0), 3);
    frm(nw(SPI_D_MASK ^ 10'h005), 1);
    rchk(SPI_OFF_PTR, 32'h30e);
    frm(nw(10'h30e), 3);
    frm(nw(10'h30e ^ SPI_I_MASK ^ 10'h007), 1);
    rchk(SPI_OFF_PTR, 32'h30e);
    check(pns, 1'b1);
    // Alarm pointer persistence
    frm(SPI_AIS_WORD, 2);
    check(pns, 1'b1);
    frm(SPI_AIS_WORD, 1);
    check({irq_b, pns}, 2'b10);
    rchk(SPI_OFF_STATUS, 32'h1);
    rchk(SPI_OFF_PEND, 32'h1);
    // Changing normal pointers are invalid in alarm state
    for (int k = 0; k < 7; k++)
      frm(nw(10'(k)), 1);
    rchk(SPI_OFF_PEND, 32'h0);
    frm(nw(10'h7), 1);
    rchk(SPI_OFF_PEND, 32'h3);
    // SDH mode: size bits checked, majority rules
    apb(1'b1, SPI_OFF_CTRL, 32'h1);
    rchk(SPI_OFF_CTRL, 32'h1);
    v = 10'($urandom % 782);
    frm({fn(SPI_FLAG_POINTER_NORMAL_STATE), 2'b00, v}, 3);
    check(pns, 1'b0);
    frm(nw(v), 3);
    check(pns, 1'b1);
    frm(nw(v ^ 10'h2a1), 1);
    rchk(SPI_OFF_PTR, {22'h0, inc(v)});
    v = inc(v);
    frm(nw(v), 3);
    frm(nw(v ^ 10'h2b5), 1);
    rchk(SPI_OFF_PTR, {22'h0, v});
    frm(nw(v), 3);
    frm(nw(v ^ 10'h152), 1);
    rchk(SPI_OFF_PTR, {22'h0, (v == 10'h0) ? 10'h30e : v - 10'h001});
    rchk(SPI_OFF_PEND, 32'h2);
    // Loss of frame alignment forces loss state
    @(posedge pclk);
    frame_lof <= 1'b1;
    @(posedge pclk);
    frame_lof <= 1'b0;
    @(negedge pclk);
    check({irq_a, pns}, 2'b10);
    finish_test();
  end
endmodule // spi_pointer_interp_tb
